// >>> hw/priority_interrupt_controller.sv
`timescale 1ns/10ps
module priority_interrupt_controller #(
    parameter int STACK_DEPTH_P = irq_ctrl_pkg::STACK_DEPTH,
    parameter int HOLD_CNT_W_P = irq_ctrl_pkg::HOLD_CNT_W
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire irq_ctrl_pkg::busReq_s bus,
    output logic [irq_ctrl_pkg::DATA_W-1:0] rdata,
    input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] srcEvent,
    input wire logic [irq_ctrl_pkg::NUM_TRAP-1:0] trapEvent,
    output irq_ctrl_pkg::coreReq_s coreReq,
    input wire logic irqAck,
    input wire logic retIrq
);
    import irq_ctrl_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    ctrlState_s st;
    ctrlState_s next_st;

    logic [LEVEL_W-1:0] candLevel [NUM_VEC];
    logic [LEVEL_W-1:0] bestLevel;
    logic [VEC_W-1:0] bestVec;
    logic anyPending;
    logic offerCore;
    logic heldBack;
    logic holdActive;
    logic [HOLD_CNT_W_P-1:0] holdRemaining;
    logic [LEVEL_W-1:0] stackLevel;
    logic takeAck;
    logic loadHold;

    assign takeAck = irqAck && st.req.valid;
    assign loadHold = bus.wr && bus.addr == ADDR_HOLD_COUNT;

    // Traps sit below the users in vector order, fixed at levels 8 up
    for (genvar i = 0; i < NUM_TRAP; i++) begin : g_trap
        assign candLevel[i] = st.trapFlags[i] ?
            LEVEL_W'(LEVEL_TRAP_BASE + LEVEL_W'(i)) : '0;
    end

    for (genvar j = 0; j < NUM_SRC; j++) begin : g_src
        logic holdMasked;
        assign holdMasked = holdActive && st.prio[j] <= HOLD_MASK_TOP;
        // Zero priority yields level 0, which never beats any CPU level
        assign candLevel[NUM_TRAP + j] =
            (st.flags[j] && st.enables[j] && !holdMasked) ?
            {1'b0, st.prio[j]} : '0;

        a_user_qualified: assert property (
            (coreReq.valid && coreReq.vector == VEC_W'(NUM_TRAP + j))
            |-> $past(st.enables[j] && st.prio[j] != '0))
            else $error("disabled source offered to core");
    end

    // Strict compare keeps the earlier, lower vector on a tie
    always_comb begin
        bestLevel = '0;
        bestVec = '0;
        for (int v = 0; v < NUM_VEC; v++) begin
            if (candLevel[v] > bestLevel) begin
                bestLevel = candLevel[v];
                bestVec = VEC_W'(v);
            end
        end
    end

    assign anyPending = (bestLevel != '0);
    assign offerCore = anyPending && bestLevel > st.cpuLevel;
    assign heldBack = anyPending && !offerCore;

    always_comb begin
        next_st = st;
        next_st.rdata = '0;
        next_st.popPending = retIrq;

        if (bus.wr) begin
            case (bus.addr)
                ADDR_FLAGS: begin
                    next_st.flags = bus.wdata[NUM_SRC-1:0];
                end
                ADDR_ENABLES: begin
                    next_st.enables = bus.wdata[NUM_SRC-1:0];
                end
                ADDR_PRIO_LO: begin
                    for (int k = 0; k < PRIO_PER_REG; k++) begin
                        next_st.prio[k] = bus.wdata[k*PRIO_STRIDE +: PRIO_W];
                    end
                end
                ADDR_PRIO_HI: begin
                    for (int k = 0; k < PRIO_PER_REG; k++) begin
                        if (k + PRIO_PER_REG < WAKE_SRC) begin
                            next_st.prio[k + PRIO_PER_REG] =
                                bus.wdata[k*PRIO_STRIDE +: PRIO_W];
                        end
                    end
                end
                ADDR_WAKE_PRIO: begin
                    next_st.prio[WAKE_SRC] = bus.wdata[PRIO_W-1:0];
                end
                ADDR_CTRL_ONE: begin
                    next_st.nestDis = bus.wdata[NEST_DIS_BIT];
                    next_st.trapFlags = bus.wdata[NUM_TRAP-1:0];
                end
                ADDR_STATUS: begin
                    // Reserved bit is not stored, so it always reads zero
                    next_st.vector_hold = bus.wdata[VECTOR_HOLD_BIT];
                end
                ADDR_STATUS_LOW: begin
                    next_st.cpuLevel[PRIO_W-1:0] =
                        bus.wdata[SRL_LEVEL_LSB +: PRIO_W];
                end
                default: begin
                end
            endcase
        end

        // Hardware set wins over a software clear in the same cycle
        next_st.flags = next_st.flags | srcEvent;
        next_st.trapFlags = next_st.trapFlags | trapEvent;

        if (bus.rd) begin
            case (bus.addr)
                ADDR_FLAGS: begin
                    next_st.rdata[NUM_SRC-1:0] = st.flags;
                end
                ADDR_ENABLES: begin
                    next_st.rdata[NUM_SRC-1:0] = st.enables;
                end
                ADDR_PRIO_LO: begin
                    for (int k = 0; k < PRIO_PER_REG; k++) begin
                        next_st.rdata[k*PRIO_STRIDE +: PRIO_W] = st.prio[k];
                    end
                end
                ADDR_PRIO_HI: begin
                    for (int k = 0; k < PRIO_PER_REG; k++) begin
                        if (k + PRIO_PER_REG < WAKE_SRC) begin
                            next_st.rdata[k*PRIO_STRIDE +: PRIO_W] =
                                st.prio[k + PRIO_PER_REG];
                        end
                    end
                end
                ADDR_WAKE_PRIO: begin
                    next_st.rdata[PRIO_W-1:0] = st.prio[WAKE_SRC];
                end
                ADDR_CTRL_ONE: begin
                    next_st.rdata[NEST_DIS_BIT] = st.nestDis;
                    next_st.rdata[NUM_TRAP-1:0] = st.trapFlags;
                end
                ADDR_STATUS: begin
                    next_st.rdata[UNACKED_BIT] = heldBack;
                    next_st.rdata[VECTOR_HOLD_BIT] = st.vector_hold;
                    next_st.rdata[LEVEL_LSB +: LEVEL_W] = st.cpuLevel;
                    next_st.rdata[VEC_W-1:0] =
                        st.vector_hold ? bestVec : st.lastVec;
                end
                ADDR_STATUS_LOW: begin
                    next_st.rdata[SRL_LEVEL_LSB +: PRIO_W] =
                        st.cpuLevel[PRIO_W-1:0];
                end
                ADDR_HOLD_COUNT: begin
                    next_st.rdata[HOLD_CNT_W_P-1:0] = holdRemaining;
                end
                default: begin
                end
            endcase
        end

        if (st.popPending) begin
            next_st.cpuLevel = stackLevel;
        end

        if (takeAck) begin
            next_st.lastVec = st.req.vector;
            if (st.nestDis && st.req.level <= LEVEL_USER_TOP) begin
                next_st.cpuLevel = LEVEL_USER_TOP;
            end else begin
                next_st.cpuLevel = st.req.level;
            end
        end

        // Drop the offer for one cycle so a stale one is never acked twice
        next_st.req.valid = offerCore && !takeAck;
        next_st.req.vector = bestVec;
        next_st.req.level = bestLevel;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.prio <= {NUM_SRC{PRIO_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign coreReq = st.req;
    assign rdata = st.rdata;

    irq_hold_timer #(
        .CNT_W(HOLD_CNT_W_P)
    ) u_hold (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .load(loadHold),
        .loadValue(bus.wdata[HOLD_CNT_W_P-1:0]),
        .active(holdActive),
        .remaining(holdRemaining)
    );

    level_stack_mem #(
        .WIDTH(LEVEL_W),
        .DEPTH(STACK_DEPTH_P)
    ) u_stack (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .push(takeAck),
        .pushData(st.cpuLevel),
        .pop(retIrq),
        .popData(stackLevel),
        .empty()
    );

    a_offer_above_cpu: assert property (
        coreReq.valid |-> coreReq.level > $past(st.cpuLevel))
        else $error("offered level not above cpu level");

    a_user_masked_top: assert property (
        ($past(st.cpuLevel) >= LEVEL_USER_TOP && coreReq.valid)
        |-> coreReq.level >= LEVEL_TRAP_BASE)
        else $error("user source passed cpu level 7");

    a_trap_never_masked: assert property (
        (st.trapFlags != '0 && st.cpuLevel < LEVEL_TRAP_BASE && !takeAck) [*2]
        |-> coreReq.valid)
        else $error("pending trap not offered");

    a_hold_masks_low: assert property (
        ($past(holdActive) && coreReq.valid)
        |-> coreReq.level >= LEVEL_USER_TOP)
        else $error("timed disable let a low level through");

    a_held_back_flag: assert property (
        (bus.rd && bus.addr == ADDR_STATUS)
        |=> rdata[UNACKED_BIT] ==
        $past(bestLevel != '0 && bestLevel <= st.cpuLevel))
        else $error("unacked flag wrong");

    a_vector_pending: assert property (
        (bus.rd && bus.addr == ADDR_STATUS && st.vector_hold)
        |=> rdata[VEC_W-1:0] == $past(bestVec))
        else $error("held vector is not the best pending");

    a_vector_last_ack: assert property (
        (takeAck ##1 !takeAck ##1 (bus.rd && bus.addr == ADDR_STATUS
        && !st.vector_hold && !takeAck))
        |=> rdata[VEC_W-1:0] == $past(coreReq.vector, 3))
        else $error("vector is not the last acknowledged");

    a_level_report: assert property (
        (bus.rd && bus.addr == ADDR_STATUS)
        |=> rdata[LEVEL_LSB +: LEVEL_W] == $past(st.cpuLevel))
        else $error("reported cpu level wrong");
endmodule

// >>> hw/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

    localparam int NUM_SRC = 8;
    localparam int NUM_TRAP = 4;
    localparam int NUM_VEC = NUM_TRAP + NUM_SRC;
    localparam int PRIO_W = 3;
    localparam int LEVEL_W = 4;
    localparam int VEC_W = 7;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [LEVEL_W-1:0] LEVEL_USER_TOP = 4'h7;
    localparam logic [LEVEL_W-1:0] LEVEL_TRAP_BASE = 4'h8;
    localparam logic [PRIO_W-1:0] HOLD_MASK_TOP = 3'h6;

    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_ENABLES = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PRIO_LO = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PRIO_HI = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_LOW = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_HOLD_COUNT = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_WAKE_PRIO = 4'h8;

    localparam int UNACKED_BIT = 15;
    localparam int VECTOR_HOLD_BIT = 13;
    localparam int LEVEL_LSB = 8;
    localparam int NEST_DIS_BIT = 15;
    localparam int SRL_LEVEL_LSB = 1;
    localparam int PRIO_STRIDE = 4;
    localparam int PRIO_PER_REG = 4;
    localparam int WAKE_SRC = 7;
    localparam int HOLD_CNT_W = 14;
    localparam int STACK_DEPTH = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } busReq_s;

    typedef struct packed {
        logic valid;
        logic [VEC_W-1:0] vector;
        logic [LEVEL_W-1:0] level;
    } coreReq_s;

    typedef struct packed {
        logic [NUM_SRC-1:0] flags;
        logic [NUM_SRC-1:0] enables;
        logic [NUM_SRC-1:0][PRIO_W-1:0] prio;
        logic [NUM_TRAP-1:0] trapFlags;
        logic nestDis;
        logic vector_hold;
        logic [LEVEL_W-1:0] cpuLevel;
        logic [VEC_W-1:0] lastVec;
        logic popPending;
        coreReq_s req;
        logic [DATA_W-1:0] rdata;
    } ctrlState_s;

endpackage

// >>> hw/irq_hold_timer.sv
`timescale 1ns/10ps
module irq_hold_timer #(
    parameter int CNT_W = 14
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic load,
    input wire logic [CNT_W-1:0] loadValue,
    output logic active,
    output logic [CNT_W-1:0] remaining
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } holdState_s;

    holdState_s st;
    holdState_s next_st;

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.cnt = loadValue;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = (st.cnt != '0);
    assign remaining = st.cnt;

    a_hold_countdown: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (active && !load) |=> (remaining == $past(remaining) - 1'b1))
        else $error("hold timer did not count down");
endmodule

// >>> hw/level_stack_mem.sv
`timescale 1ns/10ps
module level_stack_mem #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    input wire logic pop,
    output logic [WIDTH-1:0] popData,
    output logic empty
);
    localparam int PTR_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] ptr;
        logic [WIDTH-1:0] rd;
    } stackState_s;

    stackState_s st;
    stackState_s next_st;

    // Overflow drops the push; underflow returns zero
    always_comb begin
        next_st = st;
        if (pop) begin
            if (st.ptr != '0) begin
                next_st.rd = st.mem[st.ptr - 1'b1];
                next_st.ptr = st.ptr - 1'b1;
            end else begin
                next_st.rd = '0;
            end
        end else if (push && st.ptr != PTR_W'(DEPTH)) begin
            next_st.mem[st.ptr] = pushData;
            next_st.ptr = st.ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign popData = st.rd;
    assign empty = (st.ptr == '0);

    // Shortest routine the core can run: push, one idle cycle, pop
    a_stack_return: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (push && !pop && st.ptr != PTR_W'(DEPTH)) ##1 (!push && !pop)
        ##1 (pop && !push) |=> (popData == $past(pushData, 3)))
        else $error("popped level differs from pushed level");
endmodule

// >>> verification/core_model.sv
`timescale 1ns/10ps
module core_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire irq_ctrl_pkg::coreReq_s coreReq,
    input wire logic ackOn,
    input wire logic [7:0] svcLen,
    output logic irqAck,
    output logic retIrq
);
    import irq_ctrl_pkg::*;

    logic busy;
    logic [7:0] cnt;

    // One routine at a time, so an ack never meets a return
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irqAck <= 1'b0;
            retIrq <= 1'b0;
            busy <= 1'b0;
            cnt <= 8'h0;
        end else begin
            irqAck <= 1'b0;
            retIrq <= 1'b0;
            if (irqAck) begin
                busy <= 1'b1;
                cnt <= svcLen;
            end else if (busy) begin
                if (cnt == 8'h0) begin
                    retIrq <= 1'b1;
                    busy <= 1'b0;
                end else begin
                    cnt <= cnt - 8'h1;
                end
            end else if (ackOn && coreReq.valid && !retIrq) begin
                irqAck <= 1'b1;
            end
        end
    end
endmodule

// >>> verification/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) check(g, e)
module tb;
    import irq_ctrl_pkg::*;

    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    busReq_s bus = '0;
    logic [DATA_W-1:0] rdata;
    logic [NUM_SRC-1:0] srcEvent = '0;
    logic [NUM_TRAP-1:0] trapEvent = '0;
    coreReq_s coreReq;
    logic irqAck;
    logic retIrq;
    logic ackOn = 1'b0;
    logic [7:0] svcLen = 8'ha;
    logic rdSeen = 1'b0;
    logic [DATA_W-1:0] rdQ[$];
    logic [VEC_W+LEVEL_W-1:0] ackQ[$];
    int nMismatch = 0;
    int testsRun = 0;
    logic [PRIO_W-1:0] pr[4];
    int best;

    always #2.5 clk_sys = ~clk_sys;

    priority_interrupt_controller #(
        .STACK_DEPTH_P(8),
        .HOLD_CNT_W_P(6)
    ) dut (
        .clk_sys(clk_sys), .nrst(nrst), .bus(bus), .rdata(rdata),
        .srcEvent(srcEvent), .trapEvent(trapEvent), .coreReq(coreReq),
        .irqAck(irqAck), .retIrq(retIrq)
    );

    core_model partner (
        .clk_sys(clk_sys), .nrst(nrst), .coreReq(coreReq), .ackOn(ackOn),
        .svcLen(svcLen), .irqAck(irqAck), .retIrq(retIrq)
    );

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rdSeen)
            `CHK(rdata, rdQ.pop_front());
        rdSeen <= bus.rd;
        if (irqAck && coreReq.valid) begin
            // An ack nobody expected compares against an impossible value
            if (ackQ.size() == 0)
                `CHK({5'h0, coreReq.vector, coreReq.level}, 16'hffff);
            else
                `CHK({5'h0, coreReq.vector, coreReq.level},
                     {5'h0, ackQ.pop_front()});
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        rdQ.push_back(e);
        bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
    endtask

    task automatic pulse(input logic [7:0] s, input logic [3:0] t);
        @(posedge clk_sys);
        srcEvent <= s;
        trapEvent <= t;
        @(posedge clk_sys);
        srcEvent <= '0;
        trapEvent <= '0;
    endtask

    task automatic expectAck(input logic [6:0] v, input logic [3:0] l);
        ackQ.push_back({v, l});
    endtask

    task automatic waitAcks;
        int i;
        // Looked at between edges, so the exit never races the ack checker
        for (i = 0; i < 500 && ackQ.size() != 0; i++)
            @(negedge clk_sys);
        if (ackQ.size() != 0) begin
            nMismatch++;
            $display("FAIL t=%0t got=%h exp=0", $time, ackQ.size());
            give_verdict();
        end
    endtask

    initial begin
        void'($urandom(32'h5ed0));
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(ADDR_PRIO_LO, 16'h4444);
        rd(ADDR_PRIO_HI, 16'h0444);
        rd(ADDR_WAKE_PRIO, 16'h0004);
        rd(ADDR_STATUS, 16'h0000);
        rd(4'h9, 16'h0000);
        // Flag left set through the first routine, so it comes back
        wr(ADDR_ENABLES, 16'h00ff);
        ackOn <= 1'b1;
        expectAck(7'h4, 4'h4);
        expectAck(7'h4, 4'h4);
        pulse(8'h01, 4'h0);
        waitAcks();
        rd(ADDR_STATUS, 16'h8404);
        wr(ADDR_FLAGS, 16'h0000);
        ackOn <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rd(ADDR_STATUS_LOW, 16'h0000);
        // Disabled source and priority zero must stay silent
        wr(ADDR_ENABLES, 16'h00fe);
        wr(ADDR_PRIO_LO, 16'h4404);
        ackOn <= 1'b1;
        pulse(8'h03, 4'h0);
        repeat (30) @(posedge clk_sys);
        rd(ADDR_STATUS, 16'h0004);
        ackOn <= 1'b0;
        wr(ADDR_FLAGS, 16'h0000);
        wr(ADDR_ENABLES, 16'h00ff);
        // Random priorities, held pending while the core looks away
        for (int j = 0; j < 4; j++)
            pr[j] = PRIO_W'($urandom_range(7, 1));
        best = 0;
        for (int j = 1; j < 4; j++)
            if (pr[j] > pr[best])
                best = j;
        wr(ADDR_PRIO_LO, {1'b0, pr[3], 1'b0, pr[2], 1'b0, pr[1], 1'b0, pr[0]});
        pulse(8'h0f, 4'h0);
        wr(ADDR_STATUS, 16'h2000);
        rd(ADDR_STATUS, 16'h2000 | 16'(NUM_TRAP + best));
        wr(ADDR_STATUS_LOW, 16'h000e);
        rd(ADDR_STATUS_LOW, 16'h000e);
        rd(ADDR_STATUS, 16'ha700 | 16'(NUM_TRAP + best));
        ackOn <= 1'b1;
        repeat (20) @(posedge clk_sys);
        expectAck(7'h0, 4'h8);
        expectAck(7'h0, 4'h8);
        pulse(8'h00, 4'h1);
        waitAcks();
        wr(ADDR_CTRL_ONE, 16'h0000);
        ackOn <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rd(ADDR_STATUS_LOW, 16'h000e);
        wr(ADDR_FLAGS, 16'h0000);
        wr(ADDR_STATUS_LOW, 16'h0000);
        // Timed disable: level 6 waits out the count, level 7 does not
        svcLen <= 8'h5;
        wr(ADDR_PRIO_LO, 16'h0006);
        wr(ADDR_PRIO_HI, 16'h0007);
        wr(ADDR_HOLD_COUNT, 16'h003c);
        ackOn <= 1'b1;
        pulse(8'h01, 4'h0);
        repeat (15) @(posedge clk_sys);
        expectAck(7'h8, 4'h7);
        pulse(8'h10, 4'h0);
        waitAcks();
        wr(ADDR_FLAGS, 16'h0001);
        repeat (20) @(posedge clk_sys);
        expectAck(7'h4, 4'h6);
        waitAcks();
        wr(ADDR_FLAGS, 16'h0000);
        ackOn <= 1'b0;
        repeat (20) @(posedge clk_sys);
        // Nesting off: a user ack lifts the level to 7; tie goes low
        wr(ADDR_CTRL_ONE, 16'h8000);
        wr(ADDR_PRIO_LO, 16'h0606);
        ackOn <= 1'b1;
        expectAck(7'h4, 4'h6);
        pulse(8'h05, 4'h0);
        waitAcks();
        rd(ADDR_STATUS, 16'ha704);
        wr(ADDR_FLAGS, 16'h0000);
        wr(ADDR_CTRL_ONE, 16'h0000);
        repeat (10) @(posedge clk_sys);
        // Instant return from level 2: the pop follows the push closely
        wr(ADDR_STATUS_LOW, 16'h0004);
        svcLen <= 8'h0;
        expectAck(7'h4, 4'h6);
        pulse(8'h01, 4'h0);
        waitAcks();
        wr(ADDR_FLAGS, 16'h0000);
        ackOn <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rd(ADDR_STATUS_LOW, 16'h0004);
        give_verdict();
    end
endmodule
